// ---- logic/sea_pkg.sv ----
// constants and types for the serial eeprom slave
package sea_pkg;
  localparam int ADDR_W = 11;
  localparam int PAGE_BYTES = 16;
  localparam int OFF_W = 4;
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [10:0] ADDR_RST = 11'h000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYC_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FILT_TIME_NS = 100;
  localparam int FILT_CYC_DEF = FILT_TIME_NS / CLK_PERIOD_NS + 1;

  typedef struct packed {
    logic [3:0] off;
    logic [7:0] data;
  } sea_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_READ
  } sea_state_t;
endpackage

// ---- logic/sea_fifo.sv ----
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module sea_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("sea_fifo: depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic push;
  logic pop;

  assign in_ready = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wptr != rptr;
  assign out_data = store[rptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      store[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule // sea_fifo

// ---- logic/sea_eeprom.sv ----
// two-wire serial eeprom slave, 2k x 8, with page write and reads
`timescale 1ns/1ns
// Overview of operation
// [RULE1] Up to sixteen data bytes per page write, committed in one write cycle.
// [RULE2] Each further data byte advances only the four low offset bits.
// [RULE3] Offset wraps inside the page; later bytes replace earlier ones.
// [RULE4] Stop after write data starts the timed cycle; inputs ignored meanwhile.
// [RULE5] Address byte during the write cycle gets no acknowledge.
// [RULE6] After the write cycle a polling address byte is acknowledged.
// [RULE7] Address counter holds last accessed address plus one.
// [RULE8] Read address byte is acknowledged, then the counter byte shifts out.
// [RULE9] Master not-acknowledge and stop end a read; data line released.
// [RULE10] Counter wraps from the top address to zero.
// [RULE11] Counter is zero after power-on reset.
// [RULE12] Dummy write sets the address for a following repeated-start read.
// [RULE13] Master acknowledge advances the address and sends the next byte.
// [RULE14] Master resets with start, nine clocks with data high, start.
// [RULE15] Software reset does nothing during the internal write cycle.
// [RULE16] Clock and data pulses of 100 ns or less are ignored.
// [RULE17] Write-protect high blocks array writes; reads unaffected.
// [RULE18] Master holds write-protect high from start through stop.
// [RULE19] Master issues software reset after unsafe power-up line states.
// [RULE20] Only device code matches are answered; others leave it standby.
// [RULE21] Address byte carries three upper address bits and direction.
// [RULE22] Write-protect low leaves writes enabled.
module sea_eeprom
#(
  parameter int PROG_CYC = sea_pkg::PROG_CYC_DEF,
  parameter int FILT_CYC = sea_pkg::FILT_CYC_DEF,
  parameter int FIFO_DEPTH = sea_pkg::PAGE_BYTES
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic wp,
  output logic busy
);
  import sea_pkg::*;

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int TW = $clog2(PROG_CYC + 1);

  if (PROG_CYC < 1 || FILT_CYC < 1 || FIFO_DEPTH < 2)
  begin : g_bad
    $error("sea_eeprom: parameter out of range");
  end

  logic [1:0] raw;
  logic [1:0] filt;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic wp_s1;
  logic wp_s2;
  logic wp_seen;
  sea_state_t st;
  logic [3:0] bitc;
  logic [7:0] sh;
  logic [7:0] byte_val;
  logic byte_done;
  logic ack_pend;
  logic rd_on;
  logic wr_pend;
  logic [2:0] upper_block_bits;
  logic [ADDR_W-1:0] addr_cnt;
  logic [OFF_W-1:0] page_offset_bits;
  logic [7:0] mem [1 << ADDR_W];
  logic [7:0] rd_byte;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pmask;
  logic [OFF_W:0] cidx;
  logic [TW-1:0] internal_program_time;
  sea_wr_t push_data;
  sea_wr_t pop_data;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;

  assign raw = {scl, sda_in};

  // synchronise and filter clock and data
  genvar gi;
  for (gi = 0; gi < 2; gi++)
  begin : g_in
    logic s1;
    logic s2;
    logic f;
    logic [FW-1:0] cnt;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        s1 <= 1'b1;
        s2 <= 1'b1;
      end
      else
      begin
        s1 <= raw[gi];
        s2 <= s1;
      end
    end
    // [RULE16] level must persist
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        f <= 1'b1;
        cnt <= '0;
      end
      else if (s2 == f)
      begin
        cnt <= '0;
      end
      else if (cnt == FW'(FILT_CYC - 1))
      begin
        f <= s2;
        cnt <= '0;
      end
      else
      begin
        cnt <= cnt + 1'b1;
      end
    end
    assign filt[gi] = f;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end
    else
    begin
      scl_q <= filt[1];
      sda_q <= filt[0];
      wp_s1 <= wp;
      wp_s2 <= wp_s1;
    end
  end

  assign scl_rise = filt[1] && !scl_q;
  assign scl_fall = !filt[1] && scl_q;
  assign start = filt[1] && scl_q && sda_q && !filt[0];
  assign stop = filt[1] && scl_q && !sda_q && filt[0];
  assign byte_val = {sh[6:0], filt[0]};
  assign byte_done = scl_rise && st != ST_IDLE && bitc == BIT_LAST;

  // protocol sequencer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= ST_IDLE;
      bitc <= '0;
      sh <= '0;
      ack_pend <= 1'b0;
      rd_on <= 1'b0;
      wr_pend <= 1'b0;
      upper_block_bits <= '0;
    end
    else if (start || stop)
    begin
      // [RULE14] start restarts parsing
      st <= start ? ST_DEV : ST_IDLE;
      bitc <= '0;
      ack_pend <= 1'b0;
      rd_on <= 1'b0;
      wr_pend <= 1'b0;
    end
    else if (scl_rise && st != ST_IDLE)
    begin
      if (bitc == BIT_ACK)
      begin
        bitc <= '0;
        ack_pend <= 1'b0;
        // [RULE9] master nack ends read
        if (st == ST_READ && filt[0])
        begin
          st <= ST_IDLE;
          rd_on <= 1'b0;
        end
      end
      else
      begin
        bitc <= bitc + 1'b1;
        sh <= byte_val;
        if (bitc == BIT_LAST)
        begin
          case (st)
            ST_DEV:
            begin
              // [RULE20] device code match
              // [RULE5] silent while busy
              if (byte_val[7:4] == DEV_CODE && !busy)
              begin
                // [RULE21] upper bits, direction
                ack_pend <= 1'b1;
                upper_block_bits <= byte_val[3:1];
                // [RULE8] read acknowledged
                st <= byte_val[0] ? ST_READ : ST_WADDR;
                rd_on <= byte_val[0];
              end
              else
              begin
                st <= ST_IDLE;
              end
            end
            ST_WADDR:
            begin
              ack_pend <= 1'b1;
              st <= ST_WDATA;
            end
            ST_WDATA:
            begin
              // [RULE1] ack while buffer has room
              ack_pend <= push_ready;
              wr_pend <= wr_pend || push_ready;
            end
            default:
            begin
              ack_pend <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // address counter and in-page offset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      // [RULE11] cleared at power-on
      addr_cnt <= ADDR_RST;
      page_offset_bits <= '0;
    end
    else if (byte_done && st == ST_WADDR)
    begin
      // [RULE12] dummy write loads address
      addr_cnt <= {upper_block_bits, byte_val};
      page_offset_bits <= byte_val[OFF_W-1:0];
    end
    else if (byte_done && st == ST_WDATA && push_ready)
    begin
      // [RULE2] low bits only
      // [RULE3] wrap inside page
      page_offset_bits <= page_offset_bits + 1'b1;
      addr_cnt <= {addr_cnt[ADDR_W-1:OFF_W], page_offset_bits + 4'h1};
    end
    else if (byte_done && st == ST_READ)
    begin
      // [RULE7] last access plus one
      // [RULE10] natural wrap to zero
      // [RULE13] next byte follows
      addr_cnt <= addr_cnt + 1'b1;
    end
  end

  assign push_valid = byte_done && st == ST_WDATA;
  assign push_data = '{off: page_offset_bits, data: byte_val};
  assign pop_ready = !(busy && cidx != '0);

  sea_fifo
  #(
    .WIDTH($bits(sea_wr_t)),
    .DEPTH(FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // page buffer fed from the fifo
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pmask <= '0;
    end
    else if (pop_valid && pop_ready)
    begin
      // [RULE3] later byte replaces earlier
      pmask[pop_data.off] <= 1'b1;
    end
    else if (start && !busy)
    begin
      pmask <= '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (pop_valid && pop_ready)
    begin
      pbuf[pop_data.off] <= pop_data.data;
    end
  end

  // write-protect seen anywhere in the sequence
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_seen <= 1'b0;
    end
    else if (start)
    begin
      wp_seen <= wp_s2;
    end
    else if (wp_s2)
    begin
      wp_seen <= 1'b1;
    end
  end

  // internal write cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      cidx <= '0;
      internal_program_time <= '0;
    end
    else if (!busy)
    begin
      // [RULE4] stop after data starts cycle
      // [RULE17] protected sequence not committed
      // [RULE22] low protect allows commit
      if (stop && wr_pend && !wp_seen && !wp_s2)
      begin
        busy <= 1'b1;
        cidx <= '0;
        internal_program_time <= '0;
      end
    end
    else if (pop_valid && cidx == '0)
    begin
      cidx <= '0;
    end
    else if (!cidx[OFF_W])
    begin
      cidx <= cidx + 1'b1;
    end
    else if (internal_program_time == TW'(PROG_CYC - 1))
    begin
      // [RULE6] ready for polling again
      busy <= 1'b0;
    end
    else
    begin
      // [RULE15] reset cannot cut it short
      internal_program_time <= internal_program_time + 1'b1;
    end
  end

  // [RULE1] one commit per page
  always_ff @(posedge clk_sys)
  begin
    if (busy && !cidx[OFF_W] && !(pop_valid && cidx == '0) && pmask[cidx[OFF_W-1:0]])
    begin
      mem[{addr_cnt[ADDR_W-1:OFF_W], cidx[OFF_W-1:0]}] <= pbuf[cidx[OFF_W-1:0]];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rd_byte <= mem[addr_cnt];
  end

  // data line drive, changes on clock fall
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      if (start || stop)
      begin
        sda_oe_n <= 1'b1;
      end
      else if (scl_fall)
      begin
        if (bitc == BIT_ACK)
        begin
          sda_oe_n <= !ack_pend;
        end
        else if (rd_on)
        begin
          // [RULE8] msb first
          sda_oe_n <= rd_byte[~bitc[2:0]];
        end
        else
        begin
          // [RULE9] released after read
          sda_oe_n <= 1'b1;
        end
      end
    end
  end
endmodule // sea_eeprom

// ---- bench/sea_eeprom_asserts.sv ----
// assertions on the eeprom slave pins
`timescale 1ns/1ns
module sea_eeprom_asserts
#(
  parameter int PROG_CYC = 1000
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic wp,
  input wire logic busy
);
  int bcnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // length of the current write cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bcnt <= 0;
    else
      bcnt <= busy ? bcnt + 1 : 0;
  end
  a_out_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_busy_quiet: assert property (busy |-> sda_oe_n)
    else $error("pin driven while busy");
  a_busy_after_stop: assert property ($rose(busy) |-> scl && sda_in && $past(scl, 4))
    else $error("write cycle without stop");
  a_busy_wp: assert property ($rose(busy) |-> !$past(wp, 4))
    else $error("write cycle under protection");
  a_busy_length: assert property ($fell(busy) |-> bcnt >= PROG_CYC - 1)
    else $error("write cycle too short");
  a_reset_idle: assert property ($rose(rstn) |-> sda_oe_n && !busy)
    else $error("outputs not idle after reset");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl)
    else $error("pin pulled while clock high");
  a_stop_release: assert property ($rose(sda_in) && scl && $past(scl) |-> sda_oe_n [*8])
    else $error("pin driven after stop");
  c_write: cover property ($rose(busy));
  c_done: cover property ($fell(busy));
  c_pull: cover property ($fell(sda_oe_n));
endmodule // sea_eeprom_asserts
bind sea_eeprom sea_eeprom_asserts #(.PROG_CYC(PROG_CYC)) u_sea_eeprom_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .wp(wp), .busy(busy));

// ---- bench/sea_master.sv ----
// two-wire bus master model, 125 ns per clock
`timescale 1ns/1ns
module sea_master
(
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #31 sda_drv = b;
    #31 scl = 1'b1;
    #31 r = sda_line;
    #32;
  endtask
  task automatic start();
    scl = 1'b0;
    #31 sda_drv = 1'b1;
    #31 scl = 1'b1;
    #31 sda_drv = 1'b0;
    #32;
  endtask
  task automatic stop();
    scl = 1'b0;
    #31 sda_drv = 1'b0;
    #31 scl = 1'b1;
    #31 sda_drv = 1'b1;
    #250;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // short data dip while the clock is high, below the filter span
  task automatic glitch();
    sda_drv = 1'b0;
    #16 sda_drv = 1'b1;
    #100;
  endtask
  task automatic sw_reset();
    logic r;
    start();
    repeat (9) bit_io(1'b1, r);
    start();
  endtask
endmodule // sea_master

// ---- bench/sea_eeprom_tb.sv ----
// self-checking bench for the eeprom slave
`timescale 1ns/1ns
module sea_eeprom_tb;
  import sea_pkg::*;
  logic clk_sys, rstn, scl, sda_drv, sda_line, sda_out, sda_oe_n, wp, busy, ack;
  logic [7:0] mem_m [0:2047];
  logic [7:0] d;
  logic [31:0] seed = 32'h8F8C;
  int bad_count = 0;
  int n_compared = 0;
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  sea_eeprom #(.PROG_CYC(1000), .FILT_CYC(3)) u_sea_eeprom (.clk_sys(clk_sys), .rstn(rstn),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp(wp),
    .busy(busy));
  sea_master u_sea_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [10:0] page_addr(input logic [10:0] a, input int i);
    return {a[10:4], 4'(a[3:0] + i[3:0])};
  endfunction
  function automatic logic [7:0] dev_byte(input logic [10:0] a, input logic rd);
    return {DEV_CODE, a[10:8], rd};
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed[7:0];
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic poll();
    u_sea_master.sw_reset();
    u_sea_master.stop();
    u_sea_master.start();
    u_sea_master.wr_byte(8'hA0, ack);
    u_sea_master.stop();
    chk(ack, 1'b0);
    for (int k = 0; k < 20 && !ack; k++)
    begin
      u_sea_master.start();
      u_sea_master.wr_byte(8'hA0, ack);
      u_sea_master.stop();
    end
    chk(ack, 1'b1);
  endtask
  task automatic pwrite(input logic [10:0] a, input int n);
    logic [7:0] v;
    u_sea_master.start();
    u_sea_master.wr_byte(dev_byte(a, 1'b0), ack);
    chk(ack, 1'b1);
    u_sea_master.wr_byte(a[7:0], ack);
    for (int i = 0; i < n; i++)
    begin
      rnd(v);
      u_sea_master.wr_byte(v, ack);
      chk(ack, 1'b1);
      if (!wp)
        mem_m[page_addr(a, i)] = v;
    end
    u_sea_master.stop();
    chk(busy, !wp);
    if (!wp)
      poll();
  endtask
  task automatic cread(input logic [10:0] a, input int n);
    logic [7:0] v;
    u_sea_master.start();
    u_sea_master.wr_byte(dev_byte(a, 1'b1), ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_sea_master.rd_byte(i == n - 1, v);
      chk(v, mem_m[11'(a + i)]);
    end
    u_sea_master.stop();
  endtask
  task automatic rread(input logic [10:0] a, input int n);
    u_sea_master.start();
    u_sea_master.wr_byte(dev_byte(a, 1'b0), ack);
    u_sea_master.wr_byte(a[7:0], ack);
    chk(ack, 1'b1);
    cread(a, n);
  endtask
  initial
  begin
    #600000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    rstn = 1'b0;
    wp = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    u_sea_master.sw_reset();
    u_sea_master.stop();
    pwrite(11'h7F0, 16);
    pwrite(11'h000, 16);
    rnd(d);
    // eighteen bytes wrap in the page
    pwrite({3'h3, d}, 18);
    rread({3'h3, d[7:4], 4'h0}, 16);
    // read across the top of memory
    rread(11'h7F8, 16);
    cread(11'h008, 2);
    @(posedge clk_sys);
    #1 wp = 1'b1;
    pwrite(11'h000, 4);
    @(posedge clk_sys);
    #1 wp = 1'b0;
    rread(11'h000, 4);
    // a filtered dip must not count as start
    u_sea_master.glitch();
    u_sea_master.wr_byte(8'hA0, ack);
    u_sea_master.stop();
    chk(ack, 1'b0);
    u_sea_master.start();
    u_sea_master.wr_byte(8'h50, ack);
    u_sea_master.stop();
    chk(ack, 1'b0);
    @(posedge clk_sys);
    #1 rstn = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    cread(11'h000, 2);
    stop_test();
  end
endmodule // sea_eeprom_tb
